// ==== bench/can_mode_control_status_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module can_mode_control_status_bench;
    import canmc_pkg::*;
    typedef struct packed {
        logic [11:0] a;
        logic [7:0]  w;
        logic [7:0]  e;
        logic        x;
    } canmc_row_type;

    logic             mclk, reset_n, psel, penable, pwrite, pready, pslverr, rx_pin;
    logic             tx_pin, cpu_wait, inject, bus_level, engine_abort, synced;
    logic             cpu_if_clk_en, wake_event, last_err, wake_seen;
    logic [11:0]      paddr;
    logic [31:0]      pwdata, prdata, q;
    int               err_total, n_compared;
    canmc_engine_type eng;
    canmc_stamp_type  stamp;
    // ack register and unmapped word must not take writes
    canmc_row_type    rows [6] = '{'{CANMC_CTL_OFFSET, 8'h2C, 8'h2C, 1'b0},
        '{CANMC_CTL_OFFSET, 8'h50, 8'h00, 1'b0}, '{CANMC_CTL_OFFSET, 8'h80, 8'h00, 1'b0},
        '{CANMC_ACK_OFFSET, 8'hFF, 8'h00, 1'b0}, '{12'h008, 8'hFF, 8'h00, 1'b1},
        '{CANMC_CTL_OFFSET, 8'h08, 8'h08, 1'b0}};

    canmc_ctl #(.ADDR_W(12)) dut (
        .mclk(mclk), .reset_n(reset_n), .clk_en(1'b1), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_receive_pin(rx_pin),
        .bus_transmit_pin(tx_pin), .engine(eng), .cpu_wait(cpu_wait),
        .bus_level(bus_level), .engine_abort(engine_abort), .bus_synchronized(synced),
        .cpu_if_clk_en(cpu_if_clk_en), .wake_event(wake_event), .stamp(stamp));

    canmc_xcvr xcvr (.tx(tx_pin), .inject_dominant(inject), .rx(rx_pin));

    // ****************************************************************
    // bus and engine tasks
    // ****************************************************************
    // one apb transfer; request held until pready seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q        = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // mode changes take a few cycles, so poll with a bound
    task automatic wait_ack(input int bitn, input logic val);
        apb(1'b0, CANMC_ACK_OFFSET, 8'h00);
        for (int i = 0; i < 20 && q[bitn] !== val; i++) apb(1'b0, CANMC_ACK_OFFSET, 8'h00);
    endtask : wait_ack

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge mclk);
            eng.bit_tick <= 1'b1;
            @(posedge mclk);
            eng.bit_tick <= 1'b0;
        end
    endtask : ticks

    task automatic stamp_chk(input logic [15:0] v);
        @(posedge mclk);
        eng.msg_acked <= 1'b1;
        @(posedge mclk);
        eng.msg_acked <= 1'b0;
        #1;
        `CHK("stamp valid", 1'b1, stamp.valid)
        `CHK("stamp value", v, stamp.value)
    endtask : stamp_chk

    task automatic frame_pulse(input int dly);
        repeat (dly) @(posedge mclk);
        eng.rx_frame_ok <= 1'b1;
        @(posedge mclk);
        eng.rx_frame_ok <= 1'b0;
    endtask : frame_pulse

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    // ****************************************************************
    // clock, watchdog and tests
    // ****************************************************************
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // whole run is a few hundred cycles; this leaves wide margin
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        give_verdict();
    end

    initial begin
        {reset_n, psel, penable, pwrite, cpu_wait, inject} = 6'b000000;
        {err_total, n_compared, paddr, pwdata} = '0;
        eng = '0;
        eng.tx_idle  = 1'b1;
        eng.tx_level = 1'b1;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        apb(1'b0, CANMC_CTL_OFFSET, 8'h00);
        `CHK("ctl reset", 32'h00000001, q)
        `CHK("tx pin reset", 1'b1, tx_pin)
        wait_ack(0, 1'b1);
        `CHK("init ack", 1'b1, q[0])
        `CHK("abort", 1'b1, engine_abort)
        apb(1'b1, CANMC_CTL_OFFSET, 8'hFD);
        apb(1'b0, CANMC_CTL_OFFSET, 8'h00);
        `CHK("ctl held", 32'h00000001, q)
        apb(1'b1, CANMC_CTL_OFFSET, 8'h00);
        wait_ack(0, 1'b0);
        `CHK("init left", 1'b0, q[0])
        $display("test reset and init done");
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].w);
            apb(1'b0, rows[i].a, 8'h00);
            `CHK("row data", {24'h000000, rows[i].e}, q)
            `CHK("row error", rows[i].x, last_err)
        end
        $display("test register rows done");
        ticks(10);
        @(negedge mclk);
        `CHK("sync early", 1'b0, synced)
        ticks(1);
        repeat (2) @(negedge mclk);
        `CHK("sync", 1'b1, synced)
        apb(1'b0, CANMC_CTL_OFFSET, 8'h00);
        `CHK("sync bit", 1'b1, q[4])
        stamp_chk(16'h000B);
        apb(1'b1, CANMC_CTL_OFFSET, 8'h00);
        apb(1'b1, CANMC_CTL_OFFSET, 8'h08);
        stamp_chk(16'h0000);
        $display("test sync and timer done");
        frame_pulse(1);
        apb(1'b0, CANMC_CTL_OFFSET, 8'h00);
        `CHK("frame set", 1'b1, q[7])
        apb(1'b1, CANMC_CTL_OFFSET, 8'h00);
        apb(1'b0, CANMC_CTL_OFFSET, 8'h00);
        `CHK("frame write zero", 1'b1, q[7])
        // clear and new frame land on the same edge
        fork
            apb(1'b1, CANMC_CTL_OFFSET, 8'h80);
            frame_pulse(2);
        join
        apb(1'b0, CANMC_CTL_OFFSET, 8'h00);
        `CHK("frame set wins", 1'b1, q[7])
        apb(1'b1, CANMC_CTL_OFFSET, 8'h80);
        apb(1'b0, CANMC_CTL_OFFSET, 8'h00);
        `CHK("frame cleared", 1'b0, q[7])
        $display("test frame flag done");
        @(posedge mclk) eng.tx_level <= 1'b0;
        repeat (4) @(negedge mclk);
        `CHK("tx dominant", 1'b0, tx_pin)
        `CHK("rx dominant", 1'b0, bus_level)
        @(posedge mclk) eng.tx_level <= 1'b1;
        repeat (4) @(negedge mclk);
        `CHK("tx recessive", 1'b1, tx_pin)
        `CHK("rx recessive", 1'b1, bus_level)
        apb(1'b1, CANMC_CTL_OFFSET, 8'h20);
        @(posedge mclk) cpu_wait <= 1'b1;
        repeat (2) @(negedge mclk);
        `CHK("cpu clock gated", 1'b0, cpu_if_clk_en)
        @(posedge mclk) cpu_wait <= 1'b0;
        repeat (2) @(negedge mclk);
        `CHK("cpu clock on", 1'b1, cpu_if_clk_en)
        $display("test pins and wait done");
        @(posedge mclk) eng.rx_busy <= 1'b1;
        apb(1'b1, CANMC_CTL_OFFSET, 8'h04);
        apb(1'b1, CANMC_CTL_OFFSET, 8'h06);
        repeat (10) @(posedge mclk);
        apb(1'b0, CANMC_CTL_OFFSET, 8'h00);
        `CHK("rx active", 1'b1, q[6])
        apb(1'b0, CANMC_ACK_OFFSET, 8'h00);
        `CHK("no sleep busy", 1'b0, q[1])
        @(posedge mclk) eng.rx_busy <= 1'b0;
        wait_ack(1, 1'b1);
        `CHK("sleep ack", 1'b1, q[1])
        @(posedge mclk) inject <= 1'b1;
        wake_seen = 1'b0;
        repeat (10) begin
            @(negedge mclk);
            if (wake_event === 1'b1) wake_seen = 1'b1;
        end
        `CHK("wake", 1'b1, wake_seen)
        @(posedge mclk) inject <= 1'b0;
        apb(1'b0, CANMC_CTL_OFFSET, 8'h00);
        `CHK("sleep req cleared", 1'b0, q[1])
        $display("test sleep and wake done");
        @(posedge mclk) eng.tx_level <= 1'b0;
        apb(1'b1, CANMC_CTL_OFFSET, 8'h01);
        @(negedge mclk);
        `CHK("tx forced", 1'b1, tx_pin)
        repeat (3) @(negedge mclk);
        `CHK("abort again", 1'b1, engine_abort)
        apb(1'b0, CANMC_CTL_OFFSET, 8'h00);
        `CHK("ctl in init", 32'h00000001, q)
        $display("test init entry done");
        give_verdict();
    end
endmodule : can_mode_control_status_bench

`default_nettype wire

// ==== bench/canmc_xcvr.sv ====
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// transceiver and bus lines
// ****************************************************************
module canmc_xcvr (
    input  wire logic tx,
    input  wire logic inject_dominant,
    output logic      rx
);
    // wired-and bus: termination pulls it recessive, any dominant wins
    assign rx = tx & ~inject_dominant;
endmodule : canmc_xcvr

`default_nettype wire

// ==== rtl/canmc_ctl.sv ====
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - transmit pin low dominant, high recessive
// - bus level comes from receive pin
// - init mode holds register at reset, mostly
// - register writable once init request bit clear
// - writes only outside init; init request always
// - reads are synchronous to internal clock
// - valid received message sets frame flag
// - frame flag sticky; write one clears
// - loopback makes frame/active bits meaningless
// - receiver active high while receiving
// - stop in wait gates cpu interface clock
// - synchronized bit set/cleared by hardware
// - timer enable runs 16-bit bit-rate timer
// - acknowledged message gets timer stamp
// - disabled timer zero; enable low in init
// - wake-up enable ends sleep on traffic
// - sleep honoured only when bus idle
// - init request aborts traffic, drops sync
// - init request forces transmit pin recessive
// - resync after eleven recessive bits
module canmc_ctl
    import canmc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic                    mclk,
    input  wire logic                    reset_n,
    input  wire logic                    clk_en,
    input  wire logic [ADDR_W-1:0]       paddr,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    bus_receive_pin,
    output logic                         bus_transmit_pin,
    input  wire canmc_pkg::canmc_engine_type engine,
    input  wire logic                    cpu_wait,
    output logic                         bus_level,
    output logic                         engine_abort,
    output logic                         bus_synchronized,
    output logic                         cpu_if_clk_en,
    output logic                         wake_event,
    output canmc_pkg::canmc_stamp_type   stamp
);
    import canmc_pkg::*;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
        addr_hit = (a[11:2] == off[11:2]);
    endfunction : addr_hit

    canmc_mode_type mode_q;
    logic [7:0]     ctl_q;
    logic           rx_meta_q;
    logic           rx_sync_q;
    logic           wake_armed_q;
    logic           wake_q;
    logic [3:0]     recessive_q;
    logic [15:0]    timer_q;
    logic           tx_q;
    logic [31:0]    prdata_q;
    canmc_stamp_type stamp_q;
    logic           init_mode;
    logic           init_ack;
    logic           sleep_ack;
    logic           access;
    logic           wr_ctl;
    logic           mapped;
    logic           bus_idle;

    assign init_ack  = (mode_q == CANMC_INIT);
    assign sleep_ack = (mode_q == CANMC_SLEEP);
    assign init_mode = ctl_q[CANMC_INIT_REQUEST_BIT] & init_ack;
    assign bus_idle  = engine.tx_idle & ~engine.rx_busy;

    // ****************************************************************
    // apb slave, zero wait states
    // ****************************************************************
    // a frozen block must not complete a transfer, so ready follows clk_en
    assign pready  = clk_en;
    assign access  = psel & penable & clk_en;
    assign mapped  = addr_hit(paddr, CANMC_CTL_OFFSET) | addr_hit(paddr, CANMC_ACK_OFFSET);
    assign pslverr = psel & penable & ~mapped;
    assign wr_ctl  = access & pwrite & pstrb[0] & addr_hit(paddr, CANMC_CTL_OFFSET);
    assign prdata  = prdata_q;

    // read data captured in the setup cycle from clocked state only
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            prdata_q <= CANMC_RDATA_RESET;
        end else if (clk_en) begin
            if (psel && !penable && !pwrite) begin
                if (addr_hit(paddr, CANMC_CTL_OFFSET)) begin
                    prdata_q <= {24'h000000, ctl_q};
                end else if (addr_hit(paddr, CANMC_ACK_OFFSET)) begin
                    prdata_q <= {30'h0000000, sleep_ack, init_ack};
                end else begin
                    prdata_q <= CANMC_RDATA_RESET;
                end
            end
        end
    end

    // ****************************************************************
    // receive pin synchroniser
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
        end else if (clk_en) begin
            rx_meta_q <= bus_receive_pin;
            rx_sync_q <= rx_meta_q;
        end
    end
    assign bus_level = rx_sync_q;

    // ****************************************************************
    // mode state machine
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mode_q <= CANMC_RUN;
        end else if (clk_en) begin
            case (mode_q)
                CANMC_RUN: begin
                    if (ctl_q[CANMC_INIT_REQUEST_BIT]) begin
                        mode_q <= CANMC_INIT;
                    end else if (ctl_q[CANMC_SLEEP_REQUEST_BIT] && bus_idle) begin
                        mode_q <= CANMC_SLEEP;
                    end
                end
                CANMC_SLEEP: begin
                    if (ctl_q[CANMC_INIT_REQUEST_BIT]) begin
                        mode_q <= CANMC_INIT;
                    end else if (!ctl_q[CANMC_SLEEP_REQUEST_BIT]) begin
                        mode_q <= CANMC_RUN;
                    end
                end
                CANMC_INIT: begin
                    if (!ctl_q[CANMC_INIT_REQUEST_BIT]) begin
                        mode_q <= CANMC_RUN;
                    end
                end
                default: begin
                    mode_q <= CANMC_RUN;
                end
            endcase
        end
    end
    assign engine_abort = init_mode;

    // ****************************************************************
    // wake-up: enable is sampled at sleep entry
    // ****************************************************************
    // a later change of the enable has no effect until the next sleep
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wake_armed_q <= 1'b0;
        end else if (clk_en && !sleep_ack) begin
            wake_armed_q <= ctl_q[CANMC_WAKEUP_ENABLE_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wake_q <= 1'b0;
        end else if (clk_en) begin
            wake_q <= sleep_ack & ctl_q[CANMC_SLEEP_REQUEST_BIT] & wake_armed_q // request gate: one pulse
                    & ~rx_sync_q & ~wake_q;
        end
    end
    assign wake_event = wake_q;

    // ****************************************************************
    // control and status register
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ctl_q <= CANMC_CTL_RESET;
        end else if (clk_en) begin
            // init request: set any time, cleared only once acknowledged
            if (wr_ctl && pwdata[CANMC_INIT_REQUEST_BIT]) begin
                ctl_q[CANMC_INIT_REQUEST_BIT] <= 1'b1;
            end else if (wr_ctl && init_ack) begin
                ctl_q[CANMC_INIT_REQUEST_BIT] <= 1'b0;
            end
            if (init_mode) begin
                // held at reset, wake-up and sleep request kept
                ctl_q[7:3] <= CANMC_CTL_RESET[7:3];
            end else begin
                // set beats the write-one clear; loopback leaves it unchecked
                if (engine.rx_frame_ok) begin
                    ctl_q[CANMC_RECEIVED_FRAME_FLAG_BIT] <= 1'b1;
                end else if (wr_ctl && !ctl_q[CANMC_INIT_REQUEST_BIT] && pwdata[CANMC_RECEIVED_FRAME_FLAG_BIT]) begin
                    ctl_q[CANMC_RECEIVED_FRAME_FLAG_BIT] <= 1'b0;
                end
                ctl_q[CANMC_RECEIVER_ACTIVE_BIT] <= engine.rx_busy & ~sleep_ack;
                ctl_q[CANMC_BUS_SYNCHRONIZED_BIT] <= ~engine.bus_off & ~ctl_q[CANMC_INIT_REQUEST_BIT]
                    & (ctl_q[CANMC_BUS_SYNCHRONIZED_BIT] | (recessive_q == CANMC_SYNC_RECESSIVE));
                if (wr_ctl && !ctl_q[CANMC_INIT_REQUEST_BIT]) begin
                    ctl_q[CANMC_STOP_IN_WAIT_BIT] <= pwdata[CANMC_STOP_IN_WAIT_BIT];
                    ctl_q[CANMC_TIME_BIT]  <= pwdata[CANMC_TIME_BIT];
                end
            end
            if (wr_ctl && !init_mode && !ctl_q[CANMC_INIT_REQUEST_BIT]) begin
                ctl_q[CANMC_WAKEUP_ENABLE_BIT] <= pwdata[CANMC_WAKEUP_ENABLE_BIT];
            end
            // sleep request: hardware clears it on wake, that clear beats software
            if (wake_q) begin
                ctl_q[CANMC_SLEEP_REQUEST_BIT] <= 1'b0;
            end else if (wr_ctl && !init_mode && !ctl_q[CANMC_INIT_REQUEST_BIT]) begin
                if (pwdata[CANMC_SLEEP_REQUEST_BIT]) begin
                    ctl_q[CANMC_SLEEP_REQUEST_BIT] <= 1'b1;
                end else if (sleep_ack || !ctl_q[CANMC_SLEEP_REQUEST_BIT]) begin
                    ctl_q[CANMC_SLEEP_REQUEST_BIT] <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // bus synchronisation: count recessive bits
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            recessive_q <= 4'h0;
        end else if (clk_en) begin
            if (init_mode || !rx_sync_q) begin
                recessive_q <= 4'h0;
            end else if (engine.bit_tick && recessive_q != CANMC_SYNC_RECESSIVE) begin
                recessive_q <= recessive_q + 4'h1;
            end
        end
    end
    assign bus_synchronized = ctl_q[CANMC_BUS_SYNCHRONIZED_BIT];

    // ****************************************************************
    // time stamp timer
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            timer_q <= CANMC_TIMER_RESET;
        end else if (clk_en) begin
            if (!ctl_q[CANMC_TIME_BIT]) begin
                timer_q <= CANMC_TIMER_RESET;
            end else if (engine.bit_tick) begin
                timer_q <= timer_q + 16'h0001;
            end
        end
    end

    // stamp goes to buffer bytes 0x0E/0x0F of the active buffer
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            stamp_q <= '0;
        end else if (clk_en) begin
            stamp_q.valid <= engine.msg_acked & ctl_q[CANMC_TIME_BIT];
            if (engine.msg_acked) begin
                stamp_q.value <= timer_q;
            end
        end
    end
    assign stamp = stamp_q;

    // ****************************************************************
    // transmit pin and cpu clock gate
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            tx_q <= 1'b1;
        end else if (clk_en) begin
            tx_q <= engine.tx_level;
        end
    end
    // forcing from flops avoids a one-cycle dominant glitch on request
    assign bus_transmit_pin = tx_q | ctl_q[CANMC_INIT_REQUEST_BIT] | sleep_ack
                            | (ctl_q[CANMC_STOP_IN_WAIT_BIT] & cpu_wait);
    assign cpu_if_clk_en = ~(ctl_q[CANMC_STOP_IN_WAIT_BIT] & cpu_wait);

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    chk_tx_init_force: assert property (
        ctl_q[CANMC_INIT_REQUEST_BIT] |-> bus_transmit_pin)
        else $error("transmit pin not recessive under init request");
    chk_frame_set_wins: assert property (
        clk_en && engine.rx_frame_ok && !init_mode |=> ctl_q[CANMC_RECEIVED_FRAME_FLAG_BIT])
        else $error("frame flag lost a set");
    chk_frame_sticky: assert property (
        clk_en && ctl_q[CANMC_RECEIVED_FRAME_FLAG_BIT] && !wr_ctl && !init_mode |=> ctl_q[CANMC_RECEIVED_FRAME_FLAG_BIT])
        else $error("frame flag cleared without write");
    chk_init_hold_bits: assert property (
        clk_en && init_mode |=> ctl_q[7:3] == CANMC_CTL_RESET[7:3])
        else $error("register not held in init mode");
    chk_timer_zero_off: assert property (
        !ctl_q[CANMC_TIME_BIT] && clk_en |=> timer_q == CANMC_TIMER_RESET)
        else $error("timer not cleared while disabled");
    chk_timer_step_tick: assert property (
        clk_en && ctl_q[CANMC_TIME_BIT] && engine.bit_tick && !init_mode
        |=> timer_q == $past(timer_q) + 16'h0001)
        else $error("timer did not advance");
    chk_sleep_when_idle: assert property (
        $rose(sleep_ack) |-> $past(bus_idle))
        else $error("sleep entered on busy bus");
    chk_init_ack_entry: assert property (
        clk_en && ctl_q[CANMC_INIT_REQUEST_BIT] && mode_q == CANMC_RUN
        |=> init_ack && !ctl_q[CANMC_BUS_SYNCHRONIZED_BIT])
        else $error("init not acknowledged");
    chk_stamp_on_ack: assert property (
        stamp.valid |-> $past(engine.msg_acked) && stamp.value == $past(timer_q))
        else $error("stamp without acknowledge");
    chk_cpu_gate_wait: assert property (
        ctl_q[CANMC_STOP_IN_WAIT_BIT] && cpu_wait |-> !cpu_if_clk_en && bus_transmit_pin)
        else $error("cpu interface clock not gated in wait");

    cov_sleep_entry: cover property ($rose(sleep_ack));
    cov_init_exit:   cover property ($fell(init_ack));
    cov_frame_set:   cover property ($rose(ctl_q[CANMC_RECEIVED_FRAME_FLAG_BIT]));
    cov_bus_synchronized_rise:  cover property ($rose(bus_synchronized));

endmodule : canmc_ctl

`default_nettype wire

// ==== rtl/canmc_pkg.sv ====
package canmc_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [11:0] CANMC_CTL_OFFSET  = 12'h000; // can_mode_control_status
    localparam logic [11:0] CANMC_ACK_OFFSET  = 12'h004; // mode acknowledges
    localparam logic [7:0]  CANMC_CTL_RESET   = 8'h01;   // init request set out of reset
    localparam logic [31:0] CANMC_RDATA_RESET = 32'h0000_0000;

    // field positions in can_mode_control_status
    localparam int CANMC_RECEIVED_FRAME_FLAG_BIT = 7;
    localparam int CANMC_RECEIVER_ACTIVE_BIT = 6;
    localparam int CANMC_STOP_IN_WAIT_BIT = 5;
    localparam int CANMC_BUS_SYNCHRONIZED_BIT = 4;
    localparam int CANMC_TIME_BIT  = 3;
    localparam int CANMC_WAKEUP_ENABLE_BIT  = 2;
    localparam int CANMC_SLEEP_REQUEST_BIT = 1;
    localparam int CANMC_INIT_REQUEST_BIT = 0;
    // field positions in the acknowledge register
    localparam int CANMC_SLEEP_ACKNOWLEDGE_BIT  = 1;
    localparam int CANMC_INIT_ACKNOWLEDGE_BIT = 0;

    // ****************************************************************
    // counts
    // ****************************************************************
    localparam logic [3:0]  CANMC_SYNC_RECESSIVE = 4'hB; // eleven recessive bits
    localparam logic [15:0] CANMC_TIMER_RESET    = 16'h0000;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        CANMC_RUN   = 2'b00,
        CANMC_INIT  = 2'b01,
        CANMC_SLEEP = 2'b10
    } canmc_mode_type;

    // status from the protocol engine, same clock domain
    typedef struct packed {
        logic rx_frame_ok; // pulse: valid message received
        logic rx_busy;     // level: receiving, also after lost arbitration
        logic tx_idle;     // level: all transmit buffers empty
        logic bit_tick;    // pulse: one per bit time
        logic msg_acked;   // pulse: message acknowledged on the bus
        logic tx_level;    // level: wanted transmit bit, 0 dominant
        logic loopback;    // level: loopback self test active
        logic bus_off;     // level: engine is bus-off
    } canmc_engine_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] value;
    } canmc_stamp_type;

endpackage : canmc_pkg
